// file: rtl/rcal_cfg.svh
/*
 * Offsets, field positions, reset values and timing counts of the
 * calendar clock core. Assumes a 200 MHz core clock.
 */
`ifndef RCAL_CFG_SVH
`define RCAL_CFG_SVH

// Register offsets
`define RCAL_A_SEC 8'h00
`define RCAL_A_MIN 8'h01
`define RCAL_A_HOUR 8'h02
`define RCAL_A_DAY 8'h03
`define RCAL_A_MON 8'h04
`define RCAL_A_YEAR 8'h05
`define RCAL_A_WEEK 8'h06
`define RCAL_A_ALSEC 8'h08
`define RCAL_A_ALMIN 8'h09
`define RCAL_A_ALHOUR 8'h0A
`define RCAL_A_ALDAY 8'h0B
`define RCAL_A_ALMON 8'h0C
`define RCAL_A_ALYEAR 8'h0D
`define RCAL_A_CTRL 8'h10
`define RCAL_A_STAT 8'h11
`define RCAL_A_INTC 8'h12
`define RCAL_A_COMPL 8'h13
`define RCAL_A_COMPH 8'h14

// Control bits
`define RCAL_C_SHADOW 7
`define RCAL_C_SNAP 6
`define RCAL_C_LOAD 5
`define RCAL_C_TEST 4
`define RCAL_C_FMT12 3
`define RCAL_C_COMP 2
`define RCAL_C_ROUND 1
`define RCAL_C_RUN 0

// Interrupt control bits
`define RCAL_I_SLEEP 4
`define RCAL_I_ALARM 3
`define RCAL_I_TIMER 2

// Writable field masks, reserved bits read zero
`define RCAL_M_SEC 8'h7F
`define RCAL_M_HOUR 8'hBF
`define RCAL_M_DAY 8'h3F
`define RCAL_M_MON 8'h1F
`define RCAL_M_WEEK 8'h07
`define RCAL_M_INTC 8'h1F

// Reset values and calendar limits
`define RCAL_RST_ONE 8'h01
`define RCAL_SEC_MAX 8'h59
`define RCAL_HOUR_MAX 8'h23
`define RCAL_MON_MAX 8'h12
`define RCAL_YEAR_MAX 8'h99
`define RCAL_WEEK_MAX 8'h06
`define RCAL_ROUND_HALF 8'h30
`define RCAL_NOON 8'h0C

// Sub-second counter terminal count
`define RCAL_SUB_TERM 15'h7FFF

// Periodic pulse length
`define RCAL_PULSE_NS 15000
`define RCAL_CLK_PS 5000
`define RCAL_PULSE_CYC (`RCAL_PULSE_NS * 1000 / `RCAL_CLK_PS)

`endif

// file: rtl/rcal_pkg.sv
/*
 * Types of the calendar clock core: serial port states, time and
 * alarm carriers, the full state record. Needs nothing else.
 */
package rcal_pkg;

   // Serial port states, one-hot
   typedef enum logic [4:0] {
      RCAL_IDLE = 5'b00001,
      RCAL_RXB = 5'b00010,
      RCAL_ACKR = 5'b00100,
      RCAL_TXB = 5'b01000,
      RCAL_ACKT = 5'b10000
   } rcal_bus_state_t;

   // Live or shadow date and time, hours kept in 24-hour BCD
   typedef struct packed {
      logic [7:0] sec;
      logic [7:0] min;
      logic [7:0] hour;
      logic [7:0] day;
      logic [7:0] mon;
      logic [7:0] year;
      logic [7:0] week;
   } rcal_time_t;

   // Alarm fields as written by the host
   typedef struct packed {
      logic [7:0] sec;
      logic [7:0] min;
      logic [7:0] hour;
      logic [7:0] day;
      logic [7:0] mon;
      logic [7:0] year;
   } rcal_alarm_t;

   // Whole state of the core
   typedef struct packed {
      logic [2:0] scl_sy;
      logic [2:0] sda_sy;
      logic [2:0] ck_sy;
      logic [1:0] slp_sy;
      rcal_bus_state_t bst;
      logic [1:0] phase;
      logic [3:0] cnt;
      logic [7:0] shift;
      logic rw;
      logic [7:0] ptr;
      logic sda_oe;
      logic sda_o;
      rcal_time_t now;
      rcal_time_t shadow;
      rcal_alarm_t alarm;
      logic [7:0] ctrl;
      logic [7:0] intc;
      logic [7:0] comp_lo;
      logic [7:0] comp_hi;
      logic pwr_flag;
      logic alarm_flag;
      logic [3:0] events;
      logic run;
      logic [14:0] sub;
      logic tick_d;
      logic per_pend;
      logic [11:0] pulse_cnt;
      logic timer_irq_n;
      logic alarm_irq_n;
   } rcal_state_t;

endpackage : rcal_pkg

// file: rtl/rcal_core.sv
/*
 * Calendar clock core with alarm, periodic pulse and a two-wire
 * register port. Assumes scl/sda, the 32 kHz clock and the sleep
 * level all arrive from outside the clk domain; the pad resolves
 * sda from sda_o and sda_oe.
 */
`timescale 1ns/1ps

module rcal_core #(
   parameter logic [6:0] DEV_ADDR = 7'h2D // Arbitrary bus address
) (
   // Clock and reset
   input wire logic clk,
   input wire logic sys_rst,
   // Two-wire register port
   input wire logic scl_i,
   input wire logic sda_i,
   output logic sda_o,
   output logic sda_oe,
   // Slow timebase and power state
   input wire logic clk32_i,
   input wire logic sleep_i,
   // Interrupt lines, active low
   output logic alarm_irq_n,
   output logic timer_irq_n
);
`include "rcal_cfg.svh"

   localparam logic [11:0] PULSE_CYC = 12'(`RCAL_PULSE_CYC);

   rcal_pkg::rcal_state_t st_r; // Registered state
   rcal_pkg::rcal_state_t st_nxt; // Next state

   // BCD increment of a two-digit value
   function automatic logic [7:0] bcd_inc(input logic [7:0] v);
      if (v[3:0] == 4'h9) begin
         bcd_inc = {v[7:4] + 4'h1, 4'h0};
      end else begin
         bcd_inc = {v[7:4], v[3:0] + 4'h1};
      end
   endfunction : bcd_inc

   // Two BCD digits to binary
   function automatic logic [7:0] bcd2bin(input logic [7:0] v);
      bcd2bin = 8'(v[7:4] * 8'h0A) + 8'(v[3:0]);
   endfunction : bcd2bin

   // Binary below one hundred to BCD
   function automatic logic [7:0] bin2bcd(input logic [7:0] b);
      bin2bcd = {4'(b / 8'h0A), 4'(b % 8'h0A)};
   endfunction : bin2bcd

   // 24-hour value to 12-hour view with meridian flag
   function automatic logic [7:0] to12(input logic [7:0] h);
      logic [7:0] b;
      logic [7:0] r;
      logic [7:0] c;
      b = bcd2bin(h);
      r = b % `RCAL_NOON;
      if (r == 8'h00) begin
         r = `RCAL_NOON;
      end
      c = bin2bcd(r);
      to12 = {b >= `RCAL_NOON, 1'b0, c[5:0]};
   endfunction : to12

   // 12-hour written value back to 24-hour storage
   function automatic logic [7:0] from12(input logic [7:0] h);
      logic [7:0] b;
      b = bcd2bin({2'b00, h[5:0]});
      if (b == `RCAL_NOON) begin
         b = 8'h00;
      end
      if (h[7]) begin
         b = b + `RCAL_NOON;
      end
      from12 = bin2bcd(b);
   endfunction : from12

   // Last day of a month, leap years every fourth
   function automatic logic [7:0] month_last(input logic [7:0] m,
                                             input logic [7:0] y);
      logic [7:0] yb;
      yb = bcd2bin(y);
      if (m == 8'h02) begin
         month_last = (yb[1:0] == 2'b00) ? 8'h29 : 8'h28;
      end else if (m == 8'h04 || m == 8'h06 || m == 8'h09 ||
                   m == 8'h11) begin
         month_last = 8'h30;
      end else begin
         month_last = 8'h31;
      end
   endfunction : month_last

   // Read data for an address, from current state
   function automatic logic [7:0] rd_byte(input rcal_pkg::rcal_state_t s,
                                          input logic [7:0] a);
      rcal_pkg::rcal_time_t t;
      t = s.ctrl[`RCAL_C_SHADOW] ? s.shadow : s.now;
      if (a == `RCAL_A_SEC) begin
         rd_byte = t.sec;
      end else if (a == `RCAL_A_MIN) begin
         rd_byte = t.min;
      end else if (a == `RCAL_A_HOUR) begin
         rd_byte = s.ctrl[`RCAL_C_FMT12] ? to12(t.hour) : t.hour;
      end else if (a == `RCAL_A_DAY) begin
         rd_byte = t.day;
      end else if (a == `RCAL_A_MON) begin
         rd_byte = t.mon;
      end else if (a == `RCAL_A_YEAR) begin
         rd_byte = t.year;
      end else if (a == `RCAL_A_WEEK) begin
         rd_byte = t.week;
      end else if (a == `RCAL_A_ALSEC) begin
         rd_byte = s.alarm.sec;
      end else if (a == `RCAL_A_ALMIN) begin
         rd_byte = s.alarm.min;
      end else if (a == `RCAL_A_ALHOUR) begin
         rd_byte = s.alarm.hour;
      end else if (a == `RCAL_A_ALDAY) begin
         rd_byte = s.alarm.day;
      end else if (a == `RCAL_A_ALMON) begin
         rd_byte = s.alarm.mon;
      end else if (a == `RCAL_A_ALYEAR) begin
         rd_byte = s.alarm.year;
      end else if (a == `RCAL_A_CTRL) begin
         rd_byte = s.ctrl;
      end else if (a == `RCAL_A_STAT) begin
         rd_byte = {s.pwr_flag, s.alarm_flag, s.events, s.run, 1'b0};
      end else if (a == `RCAL_A_INTC) begin
         rd_byte = s.intc;
      end else if (a == `RCAL_A_COMPL) begin
         rd_byte = s.comp_lo;
      end else if (a == `RCAL_A_COMPH) begin
         rd_byte = s.comp_hi;
      end else begin
         rd_byte = 8'h00; // Unmapped reads zero
      end
   endfunction : rd_byte

   // All next-state logic
   always_comb begin
      logic scl_rise;
      logic scl_fall;
      logic start_c;
      logic stop_c;
      logic ck_rise;
      logic sleeping;
      logic wr_en;
      logic [7:0] wd;
      logic sec_tick;
      logic rnd;
      logic min_c;
      logic hour_c;
      logic day_c;
      logic mon_c;
      logic alarm_set;
      logic per_evt;
      logic [7:0] hview;
      logic [7:0] rb; // Read byte at the current pointer
      st_nxt = st_r;
      rb = rd_byte(st_r, st_r.ptr);
      wr_en = 1'b0;
      wd = st_r.shift;
      sec_tick = 1'b0;
      rnd = 1'b0;
      min_c = 1'b0;
      hour_c = 1'b0;
      day_c = 1'b0;
      mon_c = 1'b0;
      alarm_set = 1'b0;
      // Two-flop synchronisers, plus one history stage on scl, sda and the slow clock
      st_nxt.scl_sy = {st_r.scl_sy[1:0], scl_i};
      st_nxt.sda_sy = {st_r.sda_sy[1:0], sda_i};
      st_nxt.ck_sy = {st_r.ck_sy[1:0], clk32_i};
      st_nxt.slp_sy = {st_r.slp_sy[0], sleep_i};
      scl_rise = st_r.scl_sy[1] & ~st_r.scl_sy[2];
      scl_fall = ~st_r.scl_sy[1] & st_r.scl_sy[2];
      start_c = st_r.scl_sy[1] & st_r.sda_sy[2] & ~st_r.sda_sy[1];
      stop_c = st_r.scl_sy[1] & ~st_r.sda_sy[2] & st_r.sda_sy[1];
      ck_rise = st_r.ck_sy[1] & ~st_r.ck_sy[2];
      sleeping = st_r.slp_sy[1];

      // Serial port state machine
      case (st_r.bst)
         rcal_pkg::RCAL_RXB: begin
            if (scl_rise) begin
               st_nxt.shift = {st_r.shift[6:0], st_r.sda_sy[1]};
               st_nxt.cnt = st_r.cnt + 4'h1;
            end else if (scl_fall && st_r.cnt == 4'h8) begin
               st_nxt.cnt = 4'h0;
               if (st_r.phase == 2'b00) begin
                  // Address byte: acknowledge only our own
                  if (st_r.shift[7:1] == DEV_ADDR) begin
                     st_nxt.rw = st_r.shift[0];
                     st_nxt.phase = 2'b01;
                     st_nxt.sda_oe = 1'b1;
                     st_nxt.bst = rcal_pkg::RCAL_ACKR;
                  end else begin
                     st_nxt.bst = rcal_pkg::RCAL_IDLE;
                  end
               end else if (st_r.phase == 2'b01) begin
                  st_nxt.ptr = st_r.shift;
                  st_nxt.phase = 2'b10;
                  st_nxt.sda_oe = 1'b1;
                  st_nxt.bst = rcal_pkg::RCAL_ACKR;
               end else begin
                  wr_en = 1'b1;
                  st_nxt.ptr = st_r.ptr + 8'h01;
                  st_nxt.sda_oe = 1'b1;
                  st_nxt.bst = rcal_pkg::RCAL_ACKR;
               end
            end
         end
         rcal_pkg::RCAL_ACKR: begin
            if (scl_fall) begin
               if (st_r.rw) begin
                  // Read: present first data bit at once
                  st_nxt.shift = rb;
                  st_nxt.sda_oe = ~rb[7];
                  st_nxt.bst = rcal_pkg::RCAL_TXB;
               end else begin
                  st_nxt.sda_oe = 1'b0;
                  st_nxt.bst = rcal_pkg::RCAL_RXB;
               end
            end
         end
         rcal_pkg::RCAL_TXB: begin
            if (scl_rise) begin
               st_nxt.cnt = st_r.cnt + 4'h1;
            end else if (scl_fall) begin
               if (st_r.cnt == 4'h8) begin
                  st_nxt.sda_oe = 1'b0;
                  st_nxt.cnt = 4'h0;
                  st_nxt.bst = rcal_pkg::RCAL_ACKT;
               end else begin
                  st_nxt.shift = {st_r.shift[6:0], 1'b0};
                  st_nxt.sda_oe = ~st_r.shift[6];
               end
            end
         end
         rcal_pkg::RCAL_ACKT: begin
            if (scl_rise) begin
               // Not acknowledged ends the read
               if (st_r.sda_sy[1]) begin
                  st_nxt.bst = rcal_pkg::RCAL_IDLE;
               end else begin
                  st_nxt.ptr = st_r.ptr + 8'h01;
                  st_nxt.cnt = 4'h1;
               end
            end else if (scl_fall && st_r.cnt == 4'h1) begin
               st_nxt.cnt = 4'h0;
               st_nxt.shift = rb;
               st_nxt.sda_oe = ~rb[7];
               st_nxt.bst = rcal_pkg::RCAL_TXB;
            end
         end
         default: begin
            st_nxt.sda_oe = 1'b0;
         end
      endcase
      // Start or repeated start wins over any byte in progress
      if (start_c) begin
         st_nxt.bst = rcal_pkg::RCAL_RXB;
         st_nxt.phase = 2'b00;
         st_nxt.cnt = 4'h0;
         st_nxt.sda_oe = 1'b0;
      end else if (stop_c) begin
         st_nxt.bst = rcal_pkg::RCAL_IDLE;
         st_nxt.sda_oe = 1'b0;
      end

      // Slow timebase: run flag follows control on slow edges
      if (ck_rise) begin
         st_nxt.run = st_r.ctrl[`RCAL_C_RUN];
         rnd = st_r.ctrl[`RCAL_C_ROUND];
         if (st_r.run) begin
            if (st_r.sub == `RCAL_SUB_TERM) begin
               st_nxt.sub = 15'h0000;
               sec_tick = 1'b1;
            end else begin
               st_nxt.sub = st_r.sub + 15'h0001;
            end
         end
      end
      // Rounding zeroes seconds, carries from half a minute up
      if (rnd) begin
         st_nxt.ctrl[`RCAL_C_ROUND] = 1'b0;
         st_nxt.now.sec = 8'h00;
         st_nxt.sub = 15'h0000;
         min_c = (st_r.now.sec >= `RCAL_ROUND_HALF);
      end else if (sec_tick) begin
         if (st_r.now.sec == `RCAL_SEC_MAX) begin
            st_nxt.now.sec = 8'h00;
            min_c = 1'b1;
         end else begin
            st_nxt.now.sec = bcd_inc(st_r.now.sec);
         end
      end
      // Carry chain through the calendar
      if (min_c) begin
         if (st_r.now.min == `RCAL_SEC_MAX) begin
            st_nxt.now.min = 8'h00;
            hour_c = 1'b1;
         end else begin
            st_nxt.now.min = bcd_inc(st_r.now.min);
         end
      end
      if (hour_c) begin
         if (st_r.now.hour == `RCAL_HOUR_MAX) begin
            st_nxt.now.hour = 8'h00;
            day_c = 1'b1;
         end else begin
            st_nxt.now.hour = bcd_inc(st_r.now.hour);
         end
      end
      if (day_c) begin
         st_nxt.now.week = (st_r.now.week == `RCAL_WEEK_MAX) ? 8'h00 :
                           st_r.now.week + 8'h01;
         if (st_r.now.day == month_last(st_r.now.mon, st_r.now.year)) begin
            st_nxt.now.day = `RCAL_RST_ONE;
            mon_c = 1'b1;
         end else begin
            st_nxt.now.day = bcd_inc(st_r.now.day);
         end
      end
      if (mon_c) begin
         if (st_r.now.mon == `RCAL_MON_MAX) begin
            st_nxt.now.mon = `RCAL_RST_ONE;
            st_nxt.now.year = (st_r.now.year == `RCAL_YEAR_MAX) ? 8'h00 :
                              bcd_inc(st_r.now.year);
         end else begin
            st_nxt.now.mon = bcd_inc(st_r.now.mon);
         end
      end
      // Elapsed flags stand until the next boundary
      if (sec_tick || rnd) begin
         st_nxt.events = {day_c, hour_c, min_c, sec_tick};
      end
      // Compensation: 15-bit start count loaded into sub at the wrap
      if (sec_tick && (st_r.ctrl[`RCAL_C_TEST] ||
                       (st_r.ctrl[`RCAL_C_COMP] && hour_c))) begin
         st_nxt.sub = 15'({st_r.comp_hi, st_r.comp_lo});
      end
      st_nxt.tick_d = sec_tick | rnd;

      // Alarm compare one cycle after the time settles
      hview = st_r.ctrl[`RCAL_C_FMT12] ? to12(st_r.now.hour) :
              st_r.now.hour;
      if (st_r.tick_d && st_r.intc[`RCAL_I_ALARM] &&
          st_r.alarm.sec == st_r.now.sec &&
          st_r.alarm.min == st_r.now.min &&
          st_r.alarm.hour == hview &&
          st_r.alarm.day == st_r.now.day &&
          st_r.alarm.mon == st_r.now.mon &&
          st_r.alarm.year == st_r.now.year) begin
         alarm_set = 1'b1;
      end

      // Periodic pulse with optional hold during sleep
      per_evt = st_r.tick_d && st_r.intc[`RCAL_I_TIMER] &&
                st_r.events[st_r.intc[1:0]];
      if (st_r.pulse_cnt != 12'h000) begin
         st_nxt.pulse_cnt = st_r.pulse_cnt - 12'h001;
         if (st_r.pulse_cnt == 12'h001) begin
            st_nxt.timer_irq_n = 1'b1;
         end
      end
      if (per_evt || st_r.per_pend) begin
         if (st_r.intc[`RCAL_I_SLEEP] && sleeping) begin
            st_nxt.per_pend = 1'b1;
         end else begin
            st_nxt.per_pend = 1'b0;
            st_nxt.pulse_cnt = PULSE_CYC;
            st_nxt.timer_irq_n = 1'b0;
         end
      end

      // Register writes override the timebase for their field
      if (wr_en) begin
         if (st_r.ptr == `RCAL_A_SEC) begin
            st_nxt.now.sec = wd & `RCAL_M_SEC;
         end else if (st_r.ptr == `RCAL_A_MIN) begin
            st_nxt.now.min = wd & `RCAL_M_SEC;
         end else if (st_r.ptr == `RCAL_A_HOUR) begin
            st_nxt.now.hour = st_r.ctrl[`RCAL_C_FMT12] ? from12(wd) :
                              {2'b00, wd[5:0]};
         end else if (st_r.ptr == `RCAL_A_DAY) begin
            st_nxt.now.day = wd & `RCAL_M_DAY;
         end else if (st_r.ptr == `RCAL_A_MON) begin
            st_nxt.now.mon = wd & `RCAL_M_MON;
         end else if (st_r.ptr == `RCAL_A_YEAR) begin
            st_nxt.now.year = wd;
         end else if (st_r.ptr == `RCAL_A_WEEK) begin
            st_nxt.now.week = wd & `RCAL_M_WEEK;
         end else if (st_r.ptr == `RCAL_A_ALSEC) begin
            st_nxt.alarm.sec = wd & `RCAL_M_SEC;
         end else if (st_r.ptr == `RCAL_A_ALMIN) begin
            st_nxt.alarm.min = wd & `RCAL_M_SEC;
         end else if (st_r.ptr == `RCAL_A_ALHOUR) begin
            st_nxt.alarm.hour = st_r.ctrl[`RCAL_C_FMT12] ?
                                (wd & `RCAL_M_HOUR) : {2'b00, wd[5:0]};
         end else if (st_r.ptr == `RCAL_A_ALDAY) begin
            st_nxt.alarm.day = wd & `RCAL_M_DAY;
         end else if (st_r.ptr == `RCAL_A_ALMON) begin
            st_nxt.alarm.mon = wd & `RCAL_M_MON;
         end else if (st_r.ptr == `RCAL_A_ALYEAR) begin
            st_nxt.alarm.year = wd;
         end else if (st_r.ptr == `RCAL_A_CTRL) begin
            st_nxt.ctrl = wd;
            // Writing zero never cancels a pending round; a round
            // done this cycle stays cleared unless one is rewritten
            st_nxt.ctrl[`RCAL_C_ROUND] = (st_r.ctrl[`RCAL_C_ROUND] & ~rnd) |
                                         wd[`RCAL_C_ROUND];
            if (wd[`RCAL_C_SNAP] && !st_r.ctrl[`RCAL_C_SNAP]) begin
               st_nxt.shadow = st_r.now;
            end
            if (wd[`RCAL_C_LOAD] && !st_r.run) begin
               st_nxt.sub = 15'({st_r.comp_hi, st_r.comp_lo});
            end
         end else if (st_r.ptr == `RCAL_A_STAT) begin
            if (wd[7]) begin
               st_nxt.pwr_flag = 1'b0;
            end
            if (wd[6]) begin
               st_nxt.alarm_flag = 1'b0;
            end
         end else if (st_r.ptr == `RCAL_A_INTC) begin
            st_nxt.intc = wd & `RCAL_M_INTC;
         end else if (st_r.ptr == `RCAL_A_COMPL) begin
            st_nxt.comp_lo = wd;
         end else if (st_r.ptr == `RCAL_A_COMPH) begin
            st_nxt.comp_hi = wd;
         end
      end
      // Set beats a same-cycle clear
      if (alarm_set) begin
         st_nxt.alarm_flag = 1'b1;
      end
      st_nxt.alarm_irq_n = ~st_nxt.alarm_flag;
      st_nxt.sda_o = 1'b0;
   end

   // State register, constants only under reset
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         st_r <= '0;
         st_r.scl_sy <= 3'b111;
         st_r.sda_sy <= 3'b111;
         st_r.bst <= rcal_pkg::RCAL_IDLE;
         st_r.now.day <= `RCAL_RST_ONE;
         st_r.now.mon <= `RCAL_RST_ONE;
         st_r.shadow.day <= `RCAL_RST_ONE;
         st_r.shadow.mon <= `RCAL_RST_ONE;
         st_r.alarm.day <= `RCAL_RST_ONE;
         st_r.alarm.mon <= `RCAL_RST_ONE;
         st_r.pwr_flag <= 1'b1;
         st_r.timer_irq_n <= 1'b1;
         st_r.alarm_irq_n <= 1'b1;
      end else begin
         st_r <= st_nxt;
      end
   end

   // Outputs straight from the state register
   assign sda_o = st_r.sda_o;
   assign sda_oe = st_r.sda_oe;
   assign alarm_irq_n = st_r.alarm_irq_n;
   assign timer_irq_n = st_r.timer_irq_n;

endmodule : rcal_core

// file: verif/rcal_core_sva.sv
/* Pin checker of the calendar clock core.
   Bound to rcal_core by tb; one 200 MHz domain. */
`timescale 1ns/1ps
module rcal_core_sva (
   // Clock and reset
   input wire logic clk,
   input wire logic sys_rst,
   // Serial, slow and sleep pins
   input wire logic scl_i,
   input wire logic sda_i,
   input wire logic sda_o,
   input wire logic sda_oe,
   input wire logic clk32_i,
   input wire logic sleep_i,
   // Interrupt lines
   input wire logic alarm_irq_n,
   input wire logic timer_irq_n
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (sys_rst);
   // Cycles the periodic line has been low
   logic [11:0] lo_r;
   logic [11:0] lo_nxt;
   always_comb lo_nxt = timer_irq_n ? 12'h000 : lo_r + 12'h001;
   // Counter register
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) lo_r <= 12'h000;
      else lo_r <= lo_nxt;
   end
   sequence s_alm_low;
      !alarm_irq_n [*8];
   endsequence
   chk_pulse_min: assert property (
      $fell(timer_irq_n) |-> !timer_irq_n [*8]) else $error("short pulse");
   chk_pulse_len: assert property (
      $rose(timer_irq_n) |-> lo_r == 12'hBB8) else $error("pulse length");
   chk_pulse_max: assert property (
      lo_r <= 12'hBB8) else $error("pulse too long");
   chk_alarm_hold: assert property (
      $fell(alarm_irq_n) |-> s_alm_low) else $error("alarm not held");
   chk_alarm_free: assert property (
      $rose(alarm_irq_n) |-> !scl_i && !$past(scl_i, 2))
      else $error("alarm freed off a write");
   chk_reset_quiet: assert property (
      $fell(sys_rst) |-> alarm_irq_n && timer_irq_n) else $error("irq");
   // Ack edges move only inside the low phase of the bus clock
   chk_oe_low_phase: assert property (
      $changed(sda_oe) |-> !$past(scl_i, 3)) else $error("ack edge");
   chk_open_drain: assert property (
      sda_oe |-> !sda_o) else $error("drives high");
endmodule : rcal_core_sva

// file: verif/rcal_host.sv
/* Host side of the two-wire register port.
   Assumes a pull-up on sda; the core only pulls low. */
`timescale 1ns/1ps
module rcal_host #(
   parameter logic [6:0] DEV_ADDR = 7'h2D // Arbitrary bus address
) (
   // Pins toward the core
   output logic scl,
   output logic sda,
   input wire logic sda_o,
   input wire logic sda_oe
);
   localparam int T = 50; // Half bit time
   logic hl = 1'b0; // Host pulls sda low
   // Wired-and line; released means high
   assign sda = !hl && !(sda_oe && !sda_o);
   initial scl = 1'b1;
   // Data moves 15 ns after scl falls, so syncs never see a false start
   task bitx(input logic b, output logic r);
      #15 hl = !b;
      #T scl = 1'b1;
      #T r = sda;
      scl = 1'b0;
   endtask : bitx
   task start;
      #15 hl = 1'b0;
      #T scl = 1'b1;
      #T hl = 1'b1;
      #T scl = 1'b0;
   endtask : start
   task stop;
      #15 hl = 1'b1;
      #T scl = 1'b1;
      #T hl = 1'b0;
      #T;
   endtask : stop
   // Byte plus ninth bit released: core acks, or host nacks on reads
   task xb(input logic [7:0] d, output logic [7:0] q);
      logic a;
      for (int i = 7; i >= 0; i--) bitx(d[i], q[i]);
      bitx(1'b1, a);
   endtask : xb
   task wr(input logic [7:0] a, input logic [7:0] d);
      logic [7:0] q;
      start;
      xb({DEV_ADDR, 1'b0}, q);
      xb(a, q);
      xb(d, q);
      stop;
   endtask : wr
   // Pointer write, restart, one byte read
   task rd(input logic [7:0] a, output logic [7:0] d);
      start;
      xb({DEV_ADDR, 1'b0}, d);
      xb(a, d);
      start;
      xb({DEV_ADDR, 1'b1}, d);
      xb(8'hFF, d);
      stop;
   endtask : rd
endmodule : rcal_host

// file: verif/tb.sv
/* Self-checking bench of the calendar clock core.
   Needs rcal_core, rcal_host and rcal_core_sva. */
`timescale 1ns/1ps
`define CHK(n, e, g) cmp_count++; if ((g) !== (e)) begin \
   $display("MISMATCH %s exp %h got %h", n, e, g); mismatches++; end
module tb;
   logic clk = 1'b0;
   logic sys_rst = 1'b1;
   logic clk32_i = 1'b0;
   logic sleep_i = 1'b0; // Raised only by the alarm test
   logic scl, sda, sda_o, sda_oe, alarm_irq_n, timer_irq_n;
   int mismatches = 0;
   int cmp_count = 0;
   logic [7:0] q;
   rcal_core dut (.clk(clk), .sys_rst(sys_rst), .scl_i(scl), .sda_i(sda),
      .sda_o(sda_o), .sda_oe(sda_oe), .clk32_i(clk32_i), .sleep_i(sleep_i),
      .alarm_irq_n(alarm_irq_n), .timer_irq_n(timer_irq_n));
   rcal_host h (.scl(scl), .sda(sda), .sda_o(sda_o), .sda_oe(sda_oe));
   initial forever #2.5 clk = ~clk;
   initial forever #40 clk32_i = ~clk32_i;
   task rchk(input logic [7:0] a, input logic [7:0] e);
      h.rd(a, q);
      `CHK("register", e, q)
   endtask : rchk
   task rchk2(input logic [7:0] a, input logic [7:0] e);
      h.rd(a, q);
      rchk(a, e);
   endtask : rchk2
   task close_out;
      $display("compares %0d mismatches %0d", cmp_count, mismatches);
      if (mismatches == 0 && cmp_count > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask : close_out
   task t_reset;
      rchk2(8'h11, 8'h80);
      rchk(8'h04, 8'h01);
      rchk(8'h0B, 8'h01);
      rchk(8'h07, 8'h00);
      h.wr(8'h06, 8'hFF);
      rchk(8'h06, 8'h07);
      h.wr(8'h05, 8'h99);
      rchk(8'h05, 8'h99);
      h.wr(8'h11, 8'h80);
      rchk2(8'h11, 8'h00);
      $display("done reset");
   endtask : t_reset
   // Sub counter loaded near its end so one second passes quickly
   // Alarm year follows the year left by the reset test
   task t_alarm;
      int n;
      sleep_i = 1'b1;
      h.wr(8'h08, 8'h01);
      h.wr(8'h0D, 8'h99);
      h.wr(8'h12, 8'h1C);
      h.wr(8'h13, 8'hF0);
      h.wr(8'h14, 8'h7F);
      h.wr(8'h10, 8'h20);
      h.wr(8'h10, 8'h01);
      for (n = 0; n < 9000 && alarm_irq_n !== 1'b0; n++) @(negedge clk);
      `CHK("alarm_irq_n", 1'b0, alarm_irq_n)
      `CHK("timer_irq_n", 1'b1, timer_irq_n)
      sleep_i = 1'b0;
      repeat (4) @(negedge clk);
      `CHK("timer_irq_n", 1'b0, timer_irq_n)
      rchk(8'h00, 8'h01);
      rchk2(8'h11, 8'h46);
      h.wr(8'h11, 8'h40);
      `CHK("alarm_irq_n", 1'b1, alarm_irq_n)
      $display("done alarm");
   endtask : t_alarm
   task t_round;
      h.wr(8'h00, 8'h45);
      h.wr(8'h10, 8'h03);
      rchk2(8'h10, 8'h01);
      rchk(8'h01, 8'h01);
      rchk(8'h00, 8'h00);
      $display("done round");
   endtask : t_round
   task t_snap;
      h.wr(8'h10, 8'h41);
      h.wr(8'h01, 8'h33);
      h.wr(8'h10, 8'h81);
      rchk(8'h01, 8'h01);
      h.wr(8'h10, 8'h01);
      rchk(8'h01, 8'h33);
      h.wr(8'h02, 8'h15);
      h.wr(8'h10, 8'h09);
      rchk(8'h02, 8'h83);
      $display("done shadow and format");
   endtask : t_snap
   initial begin
      repeat (12) @(negedge clk);
      sys_rst = 1'b0;
      repeat (3) @(negedge clk);
      t_reset;
      t_alarm;
      t_round;
      t_snap;
      close_out;
   end
   // Watchdog well past the expected run
   initial begin
      #400000;
      mismatches++;
      close_out;
   end
endmodule : tb
bind rcal_core rcal_core_sva chk (.clk(clk), .sys_rst(sys_rst),
   .scl_i(scl_i), .sda_i(sda_i), .sda_o(sda_o), .sda_oe(sda_oe),
   .clk32_i(clk32_i), .sleep_i(sleep_i), .alarm_irq_n(alarm_irq_n),
   .timer_irq_n(timer_irq_n));
